// file: rtl/fcc_pkg.sv
// package for the fuse check control block
package fcc_pkg;

  // ***********************
  // fuse check states
  // ***********************
  typedef enum logic [1:0] {
    FCC_ARMED  = 2'b00,
    FCC_ACTIVE = 2'b01,
    FCC_DONE   = 2'b10
  } fcc_state_type;

  // ***********************
  // field layout and reset values
  // ***********************
  localparam int unsigned FCC_EDGE_W     = 2;
  localparam logic [1:0]  FCC_RISE_LIMIT = 2'h2;
  localparam logic [1:0]  FCC_RISE_RESET = 2'h0;
  localparam logic        FCC_TMS_IDLE   = 1'h1;

  // shared pin mux controls
  typedef struct packed {
    logic dir;
    logic sel;
    logic sel2;
  } fcc_pinsel_type;

  // debug access status to the core
  typedef struct packed {
    logic jtag_ok;
    logic two_wire_ok;
    logic emu_ok;
    logic bypass;
  } fcc_access_type;

endpackage

// file: rtl/fcc_edge_det.sv
// tms edge detector
`timescale 1ns/100ps
`default_nettype none
module fcc_edge_det
  import fcc_pkg::*;
(
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // pin
  input  wire logic tms_i,
  // edges
  output logic      rise_o,
  output logic      fall_o
);

  logic tms_q;

  // idle level is high so a pin held low at power up reads as a fall
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tms_q <= FCC_TMS_IDLE;
    end else begin
      tms_q <= tms_i;
    end
  end

  assign rise_o = tms_i & ~tms_q;
  assign fall_o = ~tms_i & tms_q;

endmodule
`default_nettype wire

// file: rtl/fcc_fuse_check.sv
// fuse check control, debug select and fuse lockout
//
// Operation
// R1: fuse check on first port access after reset
// R2: enter on first tms fall or low
// R3: leave on second tms rise
// R4: stay inactive until next power reset
// R5: power reset rearms the activation logic
// R6: sense current only active and tms low
// R7: test terminal low ends check mode
// R8: host keeps tms high when idle
// R9: blown fuse protects code and ram
// R10: internal four-wire select overrides shared pin
// R11: blown fuse refuses debug, forces bypass
// R12: state and counter cleared by power reset
`timescale 1ns/100ps
`default_nettype none
module fcc_fuse_check
  import fcc_pkg::*;
(
  // clock and power-on reset
  input  wire logic           clk_i,
  input  wire logic           rst_i,
  // debug pins
  input  wire logic           tms_i,
  input  wire logic           test_i,
  input  wire logic           tdi_i,
  input  wire logic           debug_pulse_clock_i,
  input  wire logic           debug_pulse_sel_i,
  // fuse and four-wire select
  input  wire logic           fuse_blown_i,
  input  wire logic           four_wire_sel_i,
  // shared pin port function
  input  wire logic           port_out_i,
  input  wire fcc_pinsel_type port_sel_i,
  // outputs
  output logic                fuse_sense_current_o,
  output logic                check_active_o,
  output logic                shared_pin_o,
  output logic                shared_pin_oe_o,
  output var fcc_access_type  access_o
);

  fcc_state_type            state;
  fcc_state_type            next_state;
  logic [FCC_EDGE_W-1:0]    rise_cnt;
  logic [FCC_EDGE_W-1:0]    next_rise_cnt;
  logic                     tms_rise;
  logic                     tms_fall;
  logic                     second_rise;
  logic                     next_sense;
  logic                     next_pin;
  logic                     next_pin_oe;
  fcc_access_type           next_access;

  fcc_edge_det u_edge (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .tms_i  (tms_i),
    .rise_o (tms_rise),
    .fall_o (tms_fall)
  );

  // ***********************
  // activation state
  // ***********************
  // R3: counting tms rises
  assign second_rise   = tms_rise && (rise_cnt == FCC_RISE_LIMIT - 2'h1);
  assign next_rise_cnt = (tms_rise && rise_cnt != FCC_RISE_LIMIT) ?
                         rise_cnt + 2'h1 : rise_cnt;

  always_comb begin
    next_state = state;
    case (state)
      // R1: R2: first fall enters check
      FCC_ARMED: begin
        if (second_rise) begin
          next_state = FCC_DONE;
        end else if (tms_fall) begin
          next_state = FCC_ACTIVE;
        end
      end
      // R3: R7: exit by rise or test low
      FCC_ACTIVE: begin
        if (second_rise || !test_i) begin
          next_state = FCC_DONE;
        end
      end
      // R4: sticky until reset
      FCC_DONE: next_state = FCC_DONE;
      default:  next_state = FCC_DONE;
    endcase
  end

  // R5: R12: reset rearms; sync reset here since one clock domain
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state    <= FCC_ARMED;
      rise_cnt <= FCC_RISE_RESET;
    end else begin
      state    <= next_state;
      rise_cnt <= next_rise_cnt;
    end
  end

  // ***********************
  // sense current and pin mux
  // ***********************
  // R6: R8: current only while active and tms low
  assign next_sense = (next_state == FCC_ACTIVE) && !tms_i;

  // R10: four-wire select owns the shared pin
  assign next_pin    = four_wire_sel_i ?
                       (debug_pulse_sel_i ? debug_pulse_clock_i : tdi_i) : port_out_i;
  assign next_pin_oe = four_wire_sel_i ? 1'b0 : (port_sel_i.dir & ~port_sel_i.sel);

  // R9: R11: blown fuse shuts every debug path
  assign next_access.jtag_ok     = !fuse_blown_i;
  assign next_access.two_wire_ok = !fuse_blown_i;
  assign next_access.emu_ok      = !fuse_blown_i;
  assign next_access.bypass      = fuse_blown_i;

  // outputs registered; tdi and pulse clock are inputs to the core, so the pad stays undriven
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fuse_sense_current_o <= 1'b0;
      check_active_o       <= 1'b0;
      shared_pin_o         <= 1'b0;
      shared_pin_oe_o      <= 1'b0;
      access_o             <= '{jtag_ok: 1'b0, two_wire_ok: 1'b0, emu_ok: 1'b0, bypass: 1'b1};
    end else begin
      fuse_sense_current_o <= next_sense;
      check_active_o       <= (next_state == FCC_ACTIVE);
      shared_pin_o         <= next_pin;
      shared_pin_oe_o      <= next_pin_oe;
      access_o             <= next_access;
    end
  end

  // ***********************
  // assertions
  // ***********************
  property p_sense_needs_low;
    @(posedge clk_i) disable iff (rst_i)
      fuse_sense_current_o |-> check_active_o && !$past(tms_i);
  endproperty
  a_sense_needs_low: assert property (p_sense_needs_low) // R6
    else $error("sense current without active low tms");

  property p_fall_enters;
    @(posedge clk_i) disable iff (rst_i)
      (state == FCC_ARMED && tms_fall && !second_rise) |=> check_active_o;
  endproperty
  a_fall_enters: assert property (p_fall_enters) // R2
    else $error("tms fall did not enter check mode");

  property p_second_rise_exits;
    @(posedge clk_i) disable iff (rst_i)
      (tms_rise && rise_cnt == 2'h1) |=> (state == FCC_DONE) && !check_active_o;
  endproperty
  a_second_rise_exits: assert property (p_second_rise_exits) // R3
    else $error("second tms rise did not exit");

  property p_done_sticky;
    @(posedge clk_i) disable iff (rst_i)
      (state == FCC_DONE) |=> (state == FCC_DONE) && !fuse_sense_current_o;
  endproperty
  a_done_sticky: assert property (p_done_sticky) // R4
    else $error("check mode left done state");

  property p_reset_rearms;
    @(posedge clk_i) $fell(rst_i) |-> (state == FCC_ARMED) && rise_cnt == 2'h0;
  endproperty
  a_reset_rearms: assert property (p_reset_rearms) // R5
    else $error("reset did not rearm");

  property p_test_low_ends;
    @(posedge clk_i) disable iff (rst_i)
      (state == FCC_ACTIVE && !test_i) |=> !check_active_o ##1 !fuse_sense_current_o;
  endproperty
  a_test_low_ends: assert property (p_test_low_ends) // R7
    else $error("test low did not end check mode");

  property p_fuse_locks;
    @(posedge clk_i) disable iff (rst_i)
      fuse_blown_i |=> access_o.bypass && !access_o.jtag_ok && !access_o.two_wire_ok
                       && !access_o.emu_ok;
  endproperty
  a_fuse_locks: assert property (p_fuse_locks) // R11
    else $error("blown fuse still allows debug access");

  property p_four_wire_pin;
    @(posedge clk_i) disable iff (rst_i)
      (four_wire_sel_i && !debug_pulse_sel_i) |=> shared_pin_o == $past(tdi_i)
                                               && !shared_pin_oe_o;
  endproperty
  a_four_wire_pin: assert property (p_four_wire_pin) // R10
    else $error("shared pin not carrying tdi");

  property p_first_access;
    @(posedge clk_i) disable iff (rst_i)
      $rose(check_active_o) |-> $past(state) == FCC_ARMED;
  endproperty
  a_first_access: assert property (p_first_access) // R1
    else $error("check mode entered outside first access");

  property p_protect;
    @(posedge clk_i) disable iff (rst_i)
      fuse_blown_i [*2] |-> !access_o.jtag_ok;
  endproperty
  a_protect: assert property (p_protect) // R9
    else $error("protection lost with blown fuse");

  property p_zero_count;
    @(posedge clk_i) disable iff (rst_i)
      (state == FCC_ARMED) |-> rise_cnt <= 2'h1;
  endproperty
  a_zero_count: assert property (p_zero_count) // R12
    else $error("edge counter out of step");

  c_enter:  cover property (@(posedge clk_i) disable iff (rst_i) $rose(check_active_o));
  c_sense:  cover property (@(posedge clk_i) disable iff (rst_i) fuse_sense_current_o);
  c_exit:   cover property (@(posedge clk_i) disable iff (rst_i) $fell(check_active_o));
  c_locked: cover property (@(posedge clk_i) disable iff (rst_i) access_o.bypass);

endmodule
`default_nettype wire

// file: tb/fcc_tool_model.sv
// debug tool model driving mode-select, test and data pins
`timescale 1ns/100ps
`default_nettype none
module fcc_tool_model (
  // clock
  input  wire logic clk_i,
  // pins toward the device
  output logic      tms_o,
  output logic      test_o,
  output logic      tdi_o
);
  initial begin
    tms_o  = 1'h1;
    test_o = 1'h1;
    tdi_o  = 1'h0;
  end
  // pins move just after a rising edge
  task automatic drive(input logic tms, input logic test, input logic tdi);
    @(posedge clk_i);
    #1;
    tms_o  = tms;
    test_o = test;
    tdi_o  = tdi;
  endtask
endmodule
`default_nettype wire

// file: tb/fuse_check_control_tb_top.sv
// testbench for the fuse check control block
`timescale 1ns/100ps
`default_nettype none
module fuse_check_control_tb_top;
  import fcc_pkg::*;
  logic           clk_i, rst_i, tms, test, tdi, pclk, psel, blown, fw, pout;
  logic           sense, act, pin, oe;
  fcc_pinsel_type port_sel;
  fcc_access_type acc;
  int             fail_count, tests_run;

  fcc_tool_model i_tool (.clk_i(clk_i), .tms_o(tms), .test_o(test), .tdi_o(tdi));

  fcc_fuse_check i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .tms_i(tms), .test_i(test), .tdi_i(tdi),
    .debug_pulse_clock_i(pclk), .debug_pulse_sel_i(psel), .fuse_blown_i(blown),
    .four_wire_sel_i(fw), .port_out_i(pout), .port_sel_i(port_sel),
    .fuse_sense_current_o(sense), .check_active_o(act), .shared_pin_o(pin),
    .shared_pin_oe_o(oe), .access_o(acc)
  );

  initial begin
    clk_i = 1'h0;
    forever #5 clk_i = ~clk_i;
  end

  task automatic check(input string w, input logic [3:0] seen, input logic [3:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", w, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clk_i);
      #1;
    end
  endtask

  task automatic cs(input string w, input logic [1:0] e);
    check(w, {2'h0, act, sense}, {2'h0, e});
  endtask

  // power reset for 15 cycles with a chosen tms level
  task automatic reset(input logic lvl);
    i_tool.drive(lvl, 1'h1, 1'h0);
    rst_i = 1'h1;
    tick(15);
    check("access_rst", acc, 4'h1);
    rst_i = 1'h0;
  endtask

  task automatic step(input logic v);
    i_tool.drive(v, 1'h1, 1'h0);
    tick(2);
  endtask

  task automatic t_walk;
    reset(1'h1);
    step(1'h0);
    cs("fall1", 2'h3);
    step(1'h1);
    cs("rise1", 2'h2);
    step(1'h0);
    cs("fall2", 2'h3);
    step(1'h1);
    cs("rise2", 2'h0);
    step(1'h0);
    cs("after", 2'h0);
    $display("test walk done");
  endtask

  task automatic t_test_low;
    reset(1'h1);
    step(1'h0);
    cs("entry", 2'h3);
    i_tool.drive(1'h0, 1'h0, 1'h0);
    tick(2);
    cs("test_low", 2'h0);
    step(1'h1);
    step(1'h0);
    cs("locked", 2'h0);
    $display("test test_low done");
  endtask

  task automatic t_rearm;
    reset(1'h0);
    tick(2);
    cs("held_low", 2'h3);
    step(1'h1);
    cs("held_rise", 2'h2);
    $display("test rearm done");
  endtask

  task automatic t_pin;
    reset(1'h1);
    i_tool.drive(1'h1, 1'h1, 1'h1);
    fw = 1'h1;
    port_sel.dir  = 1'h1;
    port_sel.sel  = 1'h0;
    port_sel.sel2 = 1'h0;
    tick(2);
    check("pin_tdi", {2'h0, pin, oe}, 4'h2);
    psel = 1'h1;
    tick(2);
    check("pin_pclk", {2'h0, pin, oe}, 4'h0);
    pclk = 1'h1;
    tick(2);
    check("pin_pclk_hi", {2'h0, pin, oe}, 4'h2);
    fw = 1'h0;
    pout = 1'h1;
    tick(2);
    check("pin_port", {2'h0, pin, oe}, 4'h3);
    $display("test pin done");
  endtask

  task automatic t_fuse;
    reset(1'h1);
    blown = 1'h1;
    tick(2);
    check("access_blown", acc, 4'h1);
    blown = 1'h0;
    tick(2);
    check("access_open", acc, 4'he);
    $display("test fuse done");
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // watchdog against a hung run
  initial begin
    #100000;
    fail_count++;
    finish_test();
  end

  initial begin
    fail_count = 0;
    tests_run  = 0;
    rst_i      = 1'h1;
    pclk       = 1'h0;
    psel       = 1'h0;
    blown      = 1'h0;
    fw         = 1'h0;
    pout       = 1'h0;
    port_sel   = '0;
    t_walk();
    t_test_low();
    t_rearm();
    t_pin();
    t_fuse();
    finish_test();
  end
endmodule
`default_nettype wire
